// *** inc/ser_defines.svh ***
// register offsets, field positions, reset values and fixed codes of the status event reporter
`ifndef SER_DEFINES_SVH
`define SER_DEFINES_SVH
`define SER_ADDR_W 4
`define SER_OPER_COND 4'h0
`define SER_OPER_EVENT 4'h1
`define SER_OPER_ENABLE 4'h2
`define SER_OPER_FALL 4'h3
`define SER_OPER_RISE 4'h4
`define SER_QUES_COND 4'h5
`define SER_QUES_EVENT 4'h6
`define SER_QUES_ENABLE 4'h7
`define SER_QUES_FALL 4'h8
`define SER_QUES_RISE 4'h9
`define SER_CONTROL 4'hA
`define SER_ERROR_QUEUE 4'hB
`define SER_VERSION 4'hC
`define SER_STATUS_BYTE 4'hD
`define SER_CTL_PRESET 0
`define SER_CTL_CLEAR 1
`define SER_CTL_WAIT 2
`define SER_OPER_DEFINED 16'h0341
`define SER_QUES_DEFINED 16'h0105
`define SER_QUES_CAL_BIT 8
`define SER_STB_OPER_BIT 7
`define SER_STB_QUES_BIT 3
`define SER_RISE_RESET 16'h7FFF
`define SER_MASK_RESET 16'h0000
`define SER_QUEUE_DEPTH 30
`define SER_ERR_OVERFLOW 16'hFEA2
`define SER_ERR_NONE 16'h0000
`define SER_VERSION_YEAR 16'h07C8
`define SER_VERSION_MINOR 16'h0000
`endif

// *** inc/ser_pkg.sv ***
// types of the status event reporter
package ser_pkg;
  typedef logic [15:0] ser_word_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ser_bus_t;
  typedef enum logic [1:0] {SER_Q_OPEN, SER_Q_LOCKED} ser_qstate_t;
endpackage : ser_pkg

// *** logic/ser_status_reporter.sv ***
// status event reporter: two status structures, error queue, preset and version
`timescale 1ns/1ns
`include "ser_defines.svh"

module ser_status_reporter (
  input wire logic clk,
  input wire logic arst_n,
  input wire ser_pkg::ser_bus_t bus,
  output logic [31:0] rdata,
  input wire logic [15:0] oper_cond_in,
  input wire logic [15:0] ques_cond_in,
  input wire logic instr_reset,
  input wire logic err_valid,
  input wire logic [15:0] err_code,
  output logic [7:0] status_byte,
  output logic completion_wait_setting,
  output logic queue_overflow
);
  import ser_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // first and second stage of each condition synchroniser
  logic [15:0] oper_meta;
  logic [15:0] oper_sync;
  logic [15:0] ques_meta;
  logic [15:0] ques_sync;

  // two flops on each condition input
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oper_meta <= 16'h0000;
      oper_sync <= 16'h0000;
      ques_meta <= 16'h0000;
      ques_sync <= 16'h0000;
    end else begin
      oper_meta <= oper_cond_in;
      oper_sync <= oper_meta;
      ques_meta <= ques_cond_in;
      ques_sync <= ques_meta;
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // address match of a register request
  function automatic logic hit(input ser_bus_t b, input logic [3:0] a);
    hit = b.addr == a;
  endfunction : hit

  // control register strobes
  logic wr_ctl;
  logic do_preset;
  logic do_clear;
  assign wr_ctl = bus.wr && hit(bus, `SER_CONTROL);
  assign do_preset = wr_ctl && bus.wdata[`SER_CTL_PRESET];
  assign do_clear = wr_ctl && bus.wdata[`SER_CTL_CLEAR];

  // ----------------------------------------
  // status structures
  // ----------------------------------------
  // index 0 operation structure, index 1 questionable structure
  ser_word_t cond [2];
  ser_word_t prev [2];
  ser_word_t event_reg [2];
  ser_word_t enable [2];
  ser_word_t fall_filter_mask [2];
  ser_word_t rise_filter_mask [2];
  logic [1:0] summary;

  // instrument reset forces idle conditions but keeps the calibration fault
  assign cond[0] = instr_reset ? 16'h0000 : (oper_sync & `SER_OPER_DEFINED);
  assign cond[1] = instr_reset ? (ques_sync & (16'h0001 << `SER_QUES_CAL_BIT))
                               : (ques_sync & `SER_QUES_DEFINED);

  // one copy of the status logic for each structure
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_struct
      logic [3:0] a_ev;
      logic [3:0] a_en;
      logic [3:0] a_fa;
      logic [3:0] a_ri;
      ser_word_t trans;
      ser_word_t next_event;
      // register offsets of this structure
      assign a_ev = (g == 0) ? `SER_OPER_EVENT : `SER_QUES_EVENT;
      assign a_en = (g == 0) ? `SER_OPER_ENABLE : `SER_QUES_ENABLE;
      assign a_fa = (g == 0) ? `SER_OPER_FALL : `SER_QUES_FALL;
      assign a_ri = (g == 0) ? `SER_OPER_RISE : `SER_QUES_RISE;
      // filtered transitions of the condition word
      assign trans = ((~cond[g] & prev[g]) & fall_filter_mask[g])
                   | ((cond[g] & ~prev[g]) & rise_filter_mask[g]);

      // previous condition for edge detection
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          prev[g] <= 16'h0000;
        end else begin
          prev[g] <= cond[g];
        end
      end

      // next event word: a clearing read or clear-status keeps only fresh transitions
      always_comb begin
        next_event = event_reg[g] | trans;
        if (do_clear || (bus.rd && hit(bus, a_ev))) begin
          next_event = trans;
        end
      end

      // latching event register; new transitions win over clears
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          event_reg[g] <= 16'h0000;
        end else begin
          event_reg[g] <= next_event;
        end
      end

      // summary enable mask: zero after preset and power-on, bit 15 dropped
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          enable[g] <= `SER_MASK_RESET;
        end else if (do_preset) begin
          enable[g] <= `SER_MASK_RESET;
        end else if (bus.wr && hit(bus, a_en)) begin
          enable[g] <= {1'b0, bus.wdata[14:0]};
        end
      end

      // fall filter mask: zero after preset and power-on, instrument reset keeps it
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          fall_filter_mask[g] <= `SER_MASK_RESET;
        end else if (do_preset) begin
          fall_filter_mask[g] <= `SER_MASK_RESET;
        end else if (bus.wr && hit(bus, a_fa)) begin
          fall_filter_mask[g] <= {1'b0, bus.wdata[14:0]};
        end
      end

      // rise filter mask: all low bits after preset and power-on
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          rise_filter_mask[g] <= `SER_RISE_RESET;
        end else if (do_preset) begin
          rise_filter_mask[g] <= `SER_RISE_RESET;
        end else if (bus.wr && hit(bus, a_ri)) begin
          rise_filter_mask[g] <= {1'b0, bus.wdata[14:0]};
        end
      end

      assign summary[g] = |(event_reg[g] & enable[g]);
    end
  endgenerate

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  // status byte from the two summaries
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_byte <= 8'h00;
    end else begin
      status_byte <= 8'h00;
      status_byte[`SER_STB_OPER_BIT] <= summary[0];
      status_byte[`SER_STB_QUES_BIT] <= summary[1];
    end
  end

  // completion wait setting: on at power-on and preset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      completion_wait_setting <= 1'b1;
    end else if (do_preset) begin
      completion_wait_setting <= 1'b1;
    end else if (wr_ctl) begin
      completion_wait_setting <= bus.wdata[`SER_CTL_WAIT];
    end
  end

  // ----------------------------------------
  // error queue
  // ----------------------------------------
  // thirty words of storage with read and write pointers
  ser_word_t queue [`SER_QUEUE_DEPTH];
  logic [4:0] rd_ptr;
  logic [4:0] wr_ptr;
  logic [5:0] count;
  ser_qstate_t qstate;
  ser_qstate_t next_qstate;
  logic q_pop;
  logic q_push;
  logic q_over;
  logic [4:0] last_ptr;

  // pointer step with wrap at the queue depth
  function automatic logic [4:0] wrap_inc(input logic [4:0] p);
    wrap_inc = (p == 5'(`SER_QUEUE_DEPTH - 1)) ? 5'h00 : p + 5'h01;
  endfunction : wrap_inc

  // queue requests; clear-status overrides pop, push and overflow
  assign q_pop = bus.rd && hit(bus, `SER_ERROR_QUEUE) && (count != 6'h00) && !do_clear;
  assign q_push = err_valid && !do_clear && (qstate == SER_Q_OPEN) && (count != 6'(`SER_QUEUE_DEPTH) || q_pop);
  assign q_over = err_valid && !do_clear && (qstate == SER_Q_OPEN) && (count == 6'(`SER_QUEUE_DEPTH)) && !q_pop;
  assign last_ptr = (wr_ptr == 5'h00) ? 5'(`SER_QUEUE_DEPTH - 1) : wr_ptr - 5'h01;

  // storage: push writes tail, overflow overwrites newest
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `SER_QUEUE_DEPTH; i++) queue[i] <= 16'h0000;
    end else if (q_push) begin
      queue[wr_ptr] <= err_code;
    end else if (q_over) begin
      queue[last_ptr] <= `SER_ERR_OVERFLOW;
    end
  end

  // read pointer: advances on every accepted pop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr <= 5'h00;
    end else if (do_clear) begin
      rd_ptr <= 5'h00;
    end else if (q_pop) begin
      rd_ptr <= wrap_inc(rd_ptr);
    end
  end

  // write pointer: advances on accepted pushes, never on overflow
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= 5'h00;
    end else if (do_clear) begin
      wr_ptr <= 5'h00;
    end else if (q_push) begin
      wr_ptr <= wrap_inc(wr_ptr);
    end
  end

  // fill count: a push and a pop in one cycle leave it unchanged
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 6'h00;
    end else if (do_clear) begin
      count <= 6'h00;
    end else begin
      count <= count + 6'(q_push) - 6'(q_pop);
    end
  end

  // ----------------------------------------
  // overflow lock
  // ----------------------------------------
  // lock after overflow until a read or clear
  always_comb begin
    next_qstate = qstate;
    case (qstate)
      SER_Q_OPEN: begin
        if (q_over) begin
          next_qstate = SER_Q_LOCKED;
        end
      end
      SER_Q_LOCKED: begin
        if (do_clear || q_pop) begin
          next_qstate = SER_Q_OPEN;
        end
      end
      default: begin
        next_qstate = SER_Q_OPEN;
      end
    endcase
  end

  // lock state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      qstate <= SER_Q_OPEN;
    end else begin
      qstate <= next_qstate;
    end
  end

  // overflow flag from its own flop, so the output carries no decode glitch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      queue_overflow <= 1'b0;
    end else begin
      queue_overflow <= next_qstate == SER_Q_LOCKED;
    end
  end

  // ----------------------------------------
  // read data, one cycle after strobe
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h00000000;
    end else if (bus.rd) begin
      case (bus.addr)
        `SER_OPER_COND: rdata <= {16'h0000, cond[0]};
        `SER_OPER_EVENT: rdata <= {16'h0000, event_reg[0]};
        `SER_OPER_ENABLE: rdata <= {16'h0000, enable[0]};
        `SER_OPER_FALL: rdata <= {16'h0000, fall_filter_mask[0]};
        `SER_OPER_RISE: rdata <= {16'h0000, rise_filter_mask[0]};
        `SER_QUES_COND: rdata <= {16'h0000, cond[1]};
        `SER_QUES_EVENT: rdata <= {16'h0000, event_reg[1]};
        `SER_QUES_ENABLE: rdata <= {16'h0000, enable[1]};
        `SER_QUES_FALL: rdata <= {16'h0000, fall_filter_mask[1]};
        `SER_QUES_RISE: rdata <= {16'h0000, rise_filter_mask[1]};
        `SER_CONTROL: rdata <= {29'h0000000, completion_wait_setting, 2'b00};
        `SER_ERROR_QUEUE: rdata <= {16'h0000, (count != 6'h00) ? queue[rd_ptr] : `SER_ERR_NONE};
        `SER_VERSION: rdata <= {`SER_VERSION_YEAR, `SER_VERSION_MINOR};
        `SER_STATUS_BYTE: rdata <= {24'h000000, status_byte};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule : ser_status_reporter

// *** dv/ser_host_model.sv ***
// command parser model: master of the register port
`timescale 1ns/1ns
module ser_host_model (
  input wire logic clk,
  output ser_pkg::ser_bus_t bus,
  input wire logic [31:0] rdata
);
  import ser_pkg::*;
  initial bus = '0;
  // one-cycle write strobe, then idle
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk) bus <= '{a, v, 1'h1, 1'h0};
    @(posedge clk) bus <= '0;
  endtask : wr
  // one-cycle read strobe, data taken in the cycle after
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk) bus <= '{a, 32'h0, 1'h0, 1'h1};
    @(posedge clk) bus <= '0;
    @(negedge clk) v = rdata;
  endtask : rd
endmodule : ser_host_model

// *** dv/ser_status_monitor.sv ***
// port assertions of the status event reporter
`timescale 1ns/1ns
`include "ser_defines.svh"
module ser_status_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire ser_pkg::ser_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic [15:0] oper_cond_in,
  input wire logic [15:0] ques_cond_in,
  input wire logic instr_reset,
  input wire logic err_valid,
  input wire logic [15:0] err_code,
  input wire logic [7:0] status_byte,
  input wire logic completion_wait_setting,
  input wire logic queue_overflow
);
  import ser_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // request decodes
  wire logic pop = bus.rd && bus.addr == `SER_ERROR_QUEUE;
  wire logic ctl = bus.wr && bus.addr == `SER_CONTROL;
  AST_STB_SPARE: assert property ((status_byte & 8'h77) == 8'h0) else $error("spare status bit set");
  AST_VERSION: assert property (bus.rd && bus.addr == `SER_VERSION |=> rdata == 32'h07C80000)
    else $error("bad version");
  AST_WIDTH: assert property (bus.rd && bus.addr <= 4'h9 |=> rdata[31:15] == 17'h0)
    else $error("bit 15 set");
  AST_OPER_BITS: assert property (bus.rd && bus.addr == 4'h0 |=> (rdata[15:0] & ~16'h0341) == 16'h0)
    else $error("undefined oper bit");
  AST_QUES_BITS: assert property (bus.rd && bus.addr == 4'h5 |=> (rdata[15:0] & ~16'h0105) == 16'h0)
    else $error("undefined ques bit");
  AST_PRESET_WAIT: assert property (ctl && bus.wdata[0] |=> completion_wait_setting)
    else $error("preset left wait off");
  AST_OVF_CAUSE: assert property ($rose(queue_overflow) |-> $past(err_valid) || $past(err_valid, 2))
    else $error("overflow without push");
  AST_OVF_HOLD: assert property (
    queue_overflow && !pop && !$past(pop) && !ctl && !$past(ctl) |=> queue_overflow)
    else $error("lock dropped");
  AST_RESET_IDLE: assert property ($rose(arst_n) |-> status_byte == 8'h0 && !queue_overflow)
    else $error("bad reset state");
  // main scenarios reached
  COV_OVF: cover property ($rose(queue_overflow));
  COV_OPER: cover property (status_byte[7]);
  COV_QUES: cover property (status_byte[3]);
  COV_VER: cover property (bus.rd && bus.addr == `SER_VERSION);
endmodule : ser_status_monitor
bind ser_status_reporter ser_status_monitor u_mon (.clk, .arst_n, .bus, .rdata, .oper_cond_in, .ques_cond_in,
  .instr_reset, .err_valid, .err_code, .status_byte, .completion_wait_setting, .queue_overflow);

// *** dv/ser_status_reporter_bench.sv ***
// self-checking bench of the status event reporter
`timescale 1ns/1ns
module ser_status_reporter_bench;
  import ser_pkg::*;
  logic clk, arst_n, instr_reset, err_valid, completion_wait_setting, queue_overflow;
  logic [15:0] oper_cond_in, ques_cond_in, err_code, r1, r2;
  logic [31:0] rdata, rv;
  logic [7:0] status_byte;
  ser_bus_t bus;
  int failures, tests_run;
  int q[$];
  bit lock;
  ser_status_reporter dut (.clk, .arst_n, .bus, .rdata, .oper_cond_in, .ques_cond_in, .instr_reset,
    .err_valid, .err_code, .status_byte, .completion_wait_setting, .queue_overflow);
  ser_host_model h (.clk, .bus, .rdata);
  // 25 MHz clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // read a register and compare
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] v;
    h.rd(a, v);
    chk(v, e);
  endtask : rc
  // one-cycle error pulse plus queue model
  task automatic push(input logic [15:0] c);
    @(posedge clk) begin
      err_valid <= 1'h1;
      err_code <= c;
    end
    @(posedge clk) err_valid <= 1'h0;
    if (!lock && q.size() < 30) q.push_back(c);
    else if (!lock) begin
      q[$] = 32'hFEA2;
      lock = 1;
    end
  endtask : push
  // read the error queue against the model; any read lifts the lock
  task automatic pop_chk;
    rc(4'hB, (q.size() > 0) ? q.pop_front() : 0);
    lock = 0;
  endtask : pop_chk
  task automatic close_out;
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  // watchdog
  initial begin
    #800000;
    failures++;
    close_out();
  end
  // main sequence
  initial begin
    arst_n = 1'h0;
    {instr_reset, err_valid, oper_cond_in, ques_cond_in, err_code} = '0;
    void'($urandom(95));
    repeat (16) @(posedge clk);
    arst_n <= 1'h1;
    rc(4'h4, 32'h7FFF);
    rc(4'h8, 32'h0);
    rc(4'h1, 32'h0);
    rc(4'hB, 32'h0);
    rc(4'hC, 32'h07C80000);
    rc(4'hA, 32'h4);
    // rise filter, summary and clearing read
    h.wr(4'h2, 32'hFFFFFFFF);
    rc(4'h2, 32'h7FFF);
    @(posedge clk) oper_cond_in <= 16'h0040;
    repeat (6) @(posedge clk);
    chk(status_byte, 8'h80);
    rc(4'h0, 32'h40);
    rc(4'h0, 32'h40);
    rc(4'h1, 32'h40);
    rc(4'h1, 32'h0);
    // fall filter only on bit 9
    h.wr(4'h4, 32'h0);
    h.wr(4'h3, 32'h0200);
    @(posedge clk) oper_cond_in <= 16'h0240;
    repeat (6) @(posedge clk);
    oper_cond_in <= 16'h0;
    repeat (6) @(posedge clk);
    rc(4'h1, 32'h200);
    // undefined bits, then instrument reset
    r1 = 16'($urandom);
    r2 = 16'($urandom) | 16'h0100;
    @(posedge clk) oper_cond_in <= r1;
    ques_cond_in <= r2;
    repeat (6) @(posedge clk);
    rc(4'h0, {16'h0, r1 & 16'h0341});
    rc(4'h5, {16'h0, r2 & 16'h0105});
    @(posedge clk) instr_reset <= 1'h1;
    repeat (4) @(posedge clk);
    rc(4'h0, 32'h0);
    rc(4'h5, 32'h100);
    rc(4'h2, 32'h7FFF);
    @(posedge clk) instr_reset <= 1'h0;
    repeat (6) @(posedge clk);
    h.wr(4'hA, 32'h2);
    rc(4'h1, 32'h0);
    rc(4'h6, 32'h0);
    // preset
    h.wr(4'hA, 32'h0);
    rc(4'hA, 32'h0);
    chk(completion_wait_setting, 1'h0);
    h.wr(4'h8, 32'h5);
    h.wr(4'hA, 32'h1);
    rc(4'hA, 32'h4);
    rc(4'h2, 32'h0);
    rc(4'h8, 32'h0);
    rc(4'h4, 32'h7FFF);
    chk(completion_wait_setting, 1'h1);
    // questionable summary on bit 3, then a rise during its clearing read
    h.wr(4'h7, 32'h7FFF);
    @(posedge clk) ques_cond_in <= 16'h0;
    repeat (6) @(posedge clk);
    ques_cond_in <= 16'h0004;
    repeat (6) @(posedge clk);
    chk(status_byte, 8'h08);
    ques_cond_in <= 16'h0005;
    @(posedge clk);
    h.rd(4'h6, rv);
    chk(rv, 32'h4);
    rc(4'h6, 32'h1);
    // error queue: overflow, push ignored while locked, drain, empty
    repeat (31) push(16'($urandom));
    @(negedge clk) chk(queue_overflow, 1'h1);
    push(16'h0123);
    repeat (30) pop_chk();
    pop_chk();
    @(negedge clk) chk(queue_overflow, 1'h0);
    // clear-status lifts the lock and empties the queue
    repeat (31) push(16'($urandom));
    h.wr(4'hA, 32'h2);
    q.delete();
    lock = 0;
    @(negedge clk) chk(queue_overflow, 1'h0);
    push(16'h0042);
    pop_chk();
    pop_chk();
    close_out();
  end
endmodule : ser_status_reporter_bench
